// ==== sic_csr_top.sv ====
// Purpose: Supervisor interrupt pending/enable, trap selection, counter gating, scratch
// Assumes: AHB-Lite slave, single word transfers, inputs synchronous to clk
// Notes:   Reads take one wait state; writes take none
`default_nettype none
`timescale 1ns/1ns

// Operation
// [R1] Cause i maps to bit i everywhere
// [R2] Bits 15:0 standard, 16 up platform
// [R3] Trap needs pending, enable, privilege gate
// [R4] Conditions re-evaluated every cycle, after return
// [R5] Supervisor interrupts precede lower-mode ones
// [R6] Writing zero clears a writable pending bit
// [R7] Read-only pending bits cleared by environment
// [R8] Enables writable if pending possible, else zero
// [R9] External pending bit 9, environment driven
// [R10] Timer pending bit 5, environment driven
// [R11] Software pending bit 1, writable, platform-settable
// [R12] Other hart's IPI sets software pending
// [R13] Unimplemented causes read zero, write-any read-legal
// [R14] All-ones enable write reveals implemented sources
// [R15] Supervisor views alias machine-level fields
// [R16] Bits 3, 7, 11 are machine causes
// [R17] Priority: external, then software, then timer
// [R18] Timer interrupts scheduled against real time
// [R19] Clear enable bit traps user counter read
// [R20] Counter enable always present, bits maybe zero
// [R21] User access needs both enable bits set
// [R22] Scratch register freely readable, writable, inert
// [R23] User mode ignores global supervisor enable
// [R24] Cycle bit0, time bit1, retired bit2
module sic_csr_top
  import sic_pkg::*;
#(
  parameter logic [15:0] IMPL_MASK     = SIC_IMPL_DEFAULT,
  parameter logic [31:0] CNT_IMPL_MASK = SIC_CNT_IMPL_DEFAULT
)(
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output var  logic [31:0]              hrdata,
  output var  logic                     hreadyout,
  output var  logic                     hresp,
  input  wire logic [1:0]               priv_mode,
  input  wire logic                     status_sie,
  input  wire logic                     supervisor_trap_return,
  input  wire logic                     sup_external_pending,
  input  wire logic                     sup_timer_pending,
  input  wire logic                     sup_software_set,
  input  wire logic [SIC_XLEN-1:0]      real_time,
  input  wire logic                     cnt_rd_valid,
  input  wire logic [SIC_CNT_IDX_W-1:0] cnt_rd_idx,
  input  wire logic [SIC_CNT_W-1:0]     mach_cnt_enable,
  output var  logic                     irq_req,
  output var  logic [SIC_CAUSE_W-1:0]   irq_cause,
  output var  logic                     cnt_illegal,
  output var  logic                     cnt_grant
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if ((IMPL_MASK & ~SIC_IMPL_LEGAL) != 16'h0000)
  begin : g_chk_impl
    $error("IMPL_MASK names a source this block cannot serve");
  end

  // ----------------------------------------------------------------
  // Address decode shared by read and write paths
  // ----------------------------------------------------------------
  function automatic logic [9:0] sic_decode(input logic [31:0] addr);
    logic [9:0] sel;
    sel = 10'h000;
    unique case (addr[7:0])
      SIC_OFF_PEND_LO: sel[0] = 1'b1;
      SIC_OFF_PEND_HI: sel[1] = 1'b1;
      SIC_OFF_EN_LO:   sel[2] = 1'b1;
      SIC_OFF_EN_HI:   sel[3] = 1'b1;
      SIC_OFF_CNTEN:   sel[4] = 1'b1;
      SIC_OFF_SCR_LO:  sel[5] = 1'b1;
      SIC_OFF_SCR_HI:  sel[6] = 1'b1;
      SIC_OFF_TCMP_LO: sel[7] = 1'b1;
      SIC_OFF_TCMP_HI: sel[8] = 1'b1;
      SIC_OFF_STATUS:  sel[9] = 1'b1;
      default:         sel = 10'h000;
    endcase
    // Anything above the low byte must be zero to hit
    if (addr[31:8] != 24'h000000)
      sel = 10'h000;
    return sel;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sic_bus_st_t             bus_st_reg;
  logic [9:0]              dp_sel_reg;
  logic                    dp_write_reg;
  logic                    soft_pend_reg;
  logic [SIC_STD_W-1:0]    en_reg;
  logic [SIC_CNT_W-1:0]    cnten_reg;
  logic [SIC_XLEN-1:0]     scratch_reg;
  logic [SIC_XLEN-1:0]     tcmp_reg;
  logic                    tcmp_hit;
  logic [SIC_STD_W-1:0]    pend_vec;
  logic [SIC_STD_W-1:0]    elig;
  logic                    glob_en;
  logic                    take_next;
  logic [SIC_CAUSE_W-1:0]  cause_next;
  logic                    addr_take;
  logic [9:0]              addr_sel;
  logic [31:0]             rd_next;
  logic                    wr_pend_lo;

  assign addr_take  = hsel && hready && (htrans == SIC_HTRANS_NONSEQ);
  assign addr_sel   = sic_decode(haddr);
  assign wr_pend_lo = dp_write_reg && dp_sel_reg[0];

  // ----------------------------------------------------------------
  // Timer compare unit
  // ----------------------------------------------------------------
  sic_tcmp #(
    .W (SIC_XLEN)
  ) u_tcmp (
    .clk       (clk),
    .rstn      (rstn),
    .real_time (real_time),
    .compare   (tcmp_reg),
    .hit       (tcmp_hit)
  );

  // ----------------------------------------------------------------
  // Bus slave: address phase capture and read wait state
  // ----------------------------------------------------------------
  // Reads wait one cycle so a write just before is always visible
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bus_st_reg   <= SIC_BUS_IDLE;
      dp_sel_reg   <= 10'h000;
      dp_write_reg <= 1'b0;
      hreadyout    <= 1'b1;
      hrdata       <= 32'h00000000;
    end
    else
    begin
      unique case (bus_st_reg)
        SIC_BUS_IDLE:
        begin
          dp_write_reg <= addr_take && hwrite;
          dp_sel_reg   <= addr_take ? addr_sel : 10'h000;
          if (addr_take && !hwrite)
          begin
            bus_st_reg <= SIC_BUS_RWAIT;
            hreadyout  <= 1'b0;
          end
        end
        SIC_BUS_RWAIT:
        begin
          dp_write_reg <= 1'b0;
          hrdata       <= rd_next;
          hreadyout    <= 1'b1;
          bus_st_reg   <= SIC_BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_next = 32'h00000000;
    unique case (1'b1)
      dp_sel_reg[0]: rd_next = {16'h0000, pend_vec};           // see [R15]
      dp_sel_reg[2]: rd_next = {16'h0000, en_reg};             // see [R14]
      dp_sel_reg[4]: rd_next = cnten_reg;
      dp_sel_reg[5]: rd_next = scratch_reg[31:0];              // see [R22]
      dp_sel_reg[6]: rd_next = scratch_reg[63:32];
      dp_sel_reg[7]: rd_next = tcmp_reg[31:0];
      dp_sel_reg[8]: rd_next = tcmp_reg[63:32];
      dp_sel_reg[9]: rd_next = {22'h00000, irq_cause, irq_req, glob_en, status_sie, priv_mode};
      // Platform halves hold no sources and read zero
      default:       rd_next = 32'h00000000;                   // see [R2]
    endcase
  end

  // ----------------------------------------------------------------
  // Pending view
  // ----------------------------------------------------------------
  // Machine causes 3, 7, 11 are never delegated here, so read zero
  always_comb
  begin
    pend_vec              = 16'h0000;                          // see [R16]
    pend_vec[SIC_BIT_EXT] = sup_external_pending;              // see [R9]
    pend_vec[SIC_BIT_TMR] = sup_timer_pending || tcmp_hit;     // see [R10]
    pend_vec[SIC_BIT_SW]  = soft_pend_reg;                     // see [R1]
    pend_vec              = pend_vec & IMPL_MASK;              // see [R13]
  end

  // Software pending: platform or IPI set beats a software clear
  always_ff @(posedge clk)
  begin
    if (!rstn)
      soft_pend_reg <= 1'b0;
    else if (sup_software_set && IMPL_MASK[SIC_BIT_SW])
      soft_pend_reg <= 1'b1;                                   // see [R11] see [R12]
    else if (wr_pend_lo)
      soft_pend_reg <= hwdata[SIC_BIT_SW] && IMPL_MASK[SIC_BIT_SW]; // see [R6]
  end
  // External and timer pending ignore bus writes; the environment
  // withdraws them (compare rewrite for the timer).  see [R7]

  // ----------------------------------------------------------------
  // Enable, counter enable, scratch, timer compare
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
      en_reg <= 16'h0000;
    else if (dp_write_reg && dp_sel_reg[2])
      en_reg <= hwdata[SIC_STD_W-1:0] & IMPL_MASK;             // see [R8] see [R14]
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      cnten_reg <= 32'h00000000;
    else if (dp_write_reg && dp_sel_reg[4])
      cnten_reg <= hwdata & CNT_IMPL_MASK;                     // see [R20] see [R21]
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      scratch_reg <= 64'h0000000000000000;
    else if (dp_write_reg && dp_sel_reg[5])
      scratch_reg[31:0] <= hwdata;                             // see [R22]
    else if (dp_write_reg && dp_sel_reg[6])
      scratch_reg[63:32] <= hwdata;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      tcmp_reg <= SIC_TCMP_RESET;
    else if (dp_write_reg && dp_sel_reg[7])
      tcmp_reg[31:0] <= hwdata;                                // see [R18]
    else if (dp_write_reg && dp_sel_reg[8])
      tcmp_reg[63:32] <= hwdata;
  end

  // ----------------------------------------------------------------
  // Trap condition and priority
  // ----------------------------------------------------------------
  // Evaluated every cycle from live inputs, so a return or any
  // enable or pending write is reflected at the very next edge.
  assign glob_en = ((priv_mode == SIC_PRIV_S) && status_sie)   // see [R3]
                || (priv_mode == SIC_PRIV_U);                  // see [R23]
  assign elig    = pend_vec & en_reg & {SIC_STD_W{glob_en}};   // see [R3]

  always_comb
  begin
    take_next  = 1'b0;
    cause_next = SIC_CAUSE_NONE;
    // No lower-mode interrupts exist here; supervisor ones win. see [R5]
    if (elig[SIC_BIT_EXT])
    begin
      take_next  = 1'b1;
      cause_next = 5'(SIC_BIT_EXT);                            // see [R17]
    end
    else if (elig[SIC_BIT_SW])
    begin
      take_next  = 1'b1;
      cause_next = 5'(SIC_BIT_SW);
    end
    else if (elig[SIC_BIT_TMR])
    begin
      take_next  = 1'b1;
      cause_next = 5'(SIC_BIT_TMR);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      irq_req   <= 1'b0;
      irq_cause <= SIC_CAUSE_NONE;
    end
    else
    begin
      irq_req   <= take_next;                                  // see [R4]
      irq_cause <= cause_next;
    end
  end

  // ----------------------------------------------------------------
  // User counter gating
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cnt_illegal <= 1'b0;
      cnt_grant   <= 1'b0;
    end
    else
    begin
      cnt_illegal <= cnt_rd_valid && (priv_mode == SIC_PRIV_U)
                  && !(cnten_reg[cnt_rd_idx] && mach_cnt_enable[cnt_rd_idx]); // see [R19] see [R24]
      cnt_grant   <= cnt_rd_valid && !((priv_mode == SIC_PRIV_U)
                  && !(cnten_reg[cnt_rd_idx] && mach_cnt_enable[cnt_rd_idx])); // see [R21]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence seq_rd_addr;
    addr_take && !hwrite && hreadyout;
  endsequence

  sequence seq_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  AST_SUP_MASKED: assert property ( // see [R3]
    (priv_mode == SIC_PRIV_S) && !status_sie |=> !irq_req)
    else $error("interrupt raised with supervisor enable clear");

  AST_USER_IGNORES_SIE: assert property ( // see [R23]
    (priv_mode == SIC_PRIV_U) && ((pend_vec & en_reg) != 16'h0000) |=> irq_req)
    else $error("user mode did not take an enabled pending interrupt");

  AST_EXT_FIRST: assert property ( // see [R17]
    elig[SIC_BIT_EXT] |=> irq_req && (irq_cause == 5'(SIC_BIT_EXT)))
    else $error("external interrupt lost priority");

  AST_SOFT_OVER_TIMER: assert property ( // see [R17]
    elig[SIC_BIT_SW] && !elig[SIC_BIT_EXT] |=> irq_cause == 5'(SIC_BIT_SW))
    else $error("software interrupt lost to timer");

  AST_SOFT_PEND_CLEAR: assert property ( // see [R6]
    wr_pend_lo && !hwdata[SIC_BIT_SW] && !sup_software_set |=> !soft_pend_reg)
    else $error("software pending not cleared by zero write");

  AST_SET_WINS: assert property ( // see [R11]
    sup_software_set && IMPL_MASK[SIC_BIT_SW] |=> soft_pend_reg && pend_vec[SIC_BIT_SW])
    else $error("platform set of software pending lost");

  AST_EN_LEGAL: assert property ( // see [R8]
    dp_write_reg && dp_sel_reg[2] |=> (en_reg & ~IMPL_MASK) == 16'h0000
      && en_reg == ($past(hwdata[SIC_STD_W-1:0]) & IMPL_MASK))
    else $error("enable holds an unimplemented bit");

  AST_CNT_TRAP: assert property ( // see [R19]
    cnt_rd_valid && (priv_mode == SIC_PRIV_U) && !cnten_reg[cnt_rd_idx]
      |=> cnt_illegal && !cnt_grant)
    else $error("user counter read not trapped");

  AST_SUPERVISOR_TRAP_RETURN_REEVAL: assert property ( // see [R4]
    supervisor_trap_return && (elig != 16'h0000) |=> irq_req)
    else $error("no re-evaluation after trap return");

  AST_READ_WAIT: assert property (
    seq_rd_addr |=> seq_rd_wait)
    else $error("read did not complete after one wait state");

endmodule
`default_nettype wire

// ==== sic_env_model.sv ====
// Purpose: Far-side model of the interrupt controller, timer source and time base
// Assumes: Bench commands are levels sampled on clk
// Notes:   External and timer levels move only here, never through the register bus
`timescale 1ns/1ns
`default_nettype none
module sic_env_model
  import sic_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                ext_cmd,
  input  wire logic                tmr_cmd,
  input  wire logic                ipi_cmd,
  output var  logic                sup_external_pending,
  output var  logic                sup_timer_pending,
  output var  logic                sup_software_set,
  output var  logic [SIC_XLEN-1:0] real_time
);
  // --------------------------------------------------------------
  // Sources
  // --------------------------------------------------------------
  // Only the controller sets or clears the external level
  always_ff @(posedge clk)
  begin
    sup_external_pending <= rstn & ext_cmd;
  end

  always_ff @(posedge clk)
  begin
    sup_timer_pending <= rstn & tmr_cmd;
  end

  // Another hart's message forces software pending
  always_ff @(posedge clk)
  begin
    sup_software_set <= rstn & ipi_cmd;
  end

  // Free-running time base for compare scheduling
  always_ff @(posedge clk)
  begin
    if (!rstn)
      real_time <= 64'h0;
    else
      real_time <= real_time + 64'h1;
  end
endmodule
`default_nettype wire

// ==== sic_pkg.sv ====
// Purpose: Shared constants for the supervisor interrupt and counter registers
// Assumes: 32-bit register bus, 64-bit supervisor register width
// Notes:   Offsets are byte addresses on the bus
`default_nettype none
package sic_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SIC_XLEN       = 64;
  localparam int SIC_BUS_W      = 32;
  localparam int SIC_STD_W      = 16;
  localparam int SIC_CNT_W      = 32;
  localparam int SIC_CAUSE_W    = 5;
  localparam int SIC_CNT_IDX_W  = 5;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SIC_OFF_PEND_LO = 8'h00;
  localparam logic [7:0] SIC_OFF_PEND_HI = 8'h04;
  localparam logic [7:0] SIC_OFF_EN_LO   = 8'h08;
  localparam logic [7:0] SIC_OFF_EN_HI   = 8'h0C;
  localparam logic [7:0] SIC_OFF_CNTEN   = 8'h10;
  localparam logic [7:0] SIC_OFF_SCR_LO  = 8'h14;
  localparam logic [7:0] SIC_OFF_SCR_HI  = 8'h18;
  localparam logic [7:0] SIC_OFF_TCMP_LO = 8'h1C;
  localparam logic [7:0] SIC_OFF_TCMP_HI = 8'h20;
  localparam logic [7:0] SIC_OFF_STATUS  = 8'h24;

  // ----------------------------------------------------------------
  // Interrupt bit positions (cause number equals bit number)
  // ----------------------------------------------------------------
  localparam int SIC_BIT_SW  = 1;
  localparam int SIC_BIT_TMR = 5;
  localparam int SIC_BIT_EXT = 9;
  localparam int SIC_BIT_MSI = 3;
  localparam int SIC_BIT_MTI = 7;
  localparam int SIC_BIT_MEI = 11;

  // Counter-enable bit positions
  localparam int SIC_CNT_CYCLE   = 0;
  localparam int SIC_CNT_TIME    = 1;
  localparam int SIC_CNT_RETIRED = 2;

  // ----------------------------------------------------------------
  // Privilege encodings and defaults
  // ----------------------------------------------------------------
  localparam logic [1:0] SIC_PRIV_U = 2'h0;
  localparam logic [1:0] SIC_PRIV_S = 2'h1;
  localparam logic [1:0] SIC_PRIV_M = 2'h3;

  localparam logic [15:0] SIC_IMPL_DEFAULT     = 16'h0222;
  localparam logic [15:0] SIC_IMPL_LEGAL       = 16'h0222;
  localparam logic [31:0] SIC_CNT_IMPL_DEFAULT = 32'hFFFFFFFF;
  localparam logic [63:0] SIC_TCMP_RESET       = 64'hFFFFFFFFFFFFFFFF;
  localparam logic [1:0]  SIC_HTRANS_NONSEQ    = 2'h2;
  localparam logic [4:0]  SIC_CAUSE_NONE       = 5'h00;

  // Bus state machine, one-hot
  typedef enum logic [1:0] {
    SIC_BUS_IDLE  = 2'b01,
    SIC_BUS_RWAIT = 2'b10
  } sic_bus_st_t;

endpackage
`default_nettype wire

// ==== sic_tcmp.sv ====
// Purpose: Timer compare against the real-time counter
// Assumes: Real-time count is synchronous to clk
// Notes:   Hit is registered; it tracks the compare every cycle
`default_nettype none
`timescale 1ns/1ns
module sic_tcmp
  import sic_pkg::*;
#(
  parameter int W = SIC_XLEN
)(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] real_time,
  input  wire logic [W-1:0] compare,
  output var  logic         hit
);

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
      hit <= 1'b0;
    else
      hit <= (real_time >= compare); // see [R18]
  end

endmodule
`default_nettype wire

// ==== supervisor_interrupt_counter_csrs_tb.sv ====
// Purpose: Self-checking bench for the supervisor interrupt and counter registers
// Assumes: AHB-Lite master here, far side in sic_env_model
// Notes:   Table rows cover trap selection and counter gating
`timescale 1ns/1ns
`default_nettype none
module supervisor_interrupt_counter_csrs_tb
  import sic_pkg::*;
;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  priv;
    logic        sie;
    logic [2:0]  en;
    logic [2:0]  src;
    logic [4:0]  cause;
    logic [31:0] cnten;
    logic [31:0] mach;
    logic [4:0]  idx;
    logic        ill;
  } sic_row_t;

  logic                     clk        = 1'b0;
  logic                     rstn       = 1'b0;
  logic                     hsel       = 1'b0;
  logic [31:0]              haddr      = 32'h0;
  logic [1:0]               htrans     = 2'h0;
  logic                     hwrite     = 1'b0;
  logic [2:0]               hsize      = 3'h2;
  logic [31:0]              hwdata     = 32'h0;
  logic [1:0]               priv_mode  = 2'h1;
  logic                     status_sie = 1'b0;
  logic                     trap_ret   = 1'b0;
  logic                     cnt_rd_valid = 1'b0;
  logic [4:0]               cnt_rd_idx = 5'h00;
  logic [31:0]              mach_en    = 32'h0;
  logic                     ext_cmd    = 1'b0;
  logic                     tmr_cmd    = 1'b0;
  logic                     ipi_cmd    = 1'b0;
  logic [31:0]              hrdata;
  logic                     hresp;
  logic                     hreadyout;
  logic                     ext_p;
  logic                     tmr_p;
  logic                     sw_set;
  logic [SIC_XLEN-1:0]      rtime;
  logic                     irq_req;
  logic [4:0]               irq_cause;
  logic                     cnt_illegal;
  logic                     cnt_grant;
  int                       n_fail     = 0;
  int                       cmp_count  = 0;
  logic [7:0]               offs [8];
  logic [31:0]              rexp [8];
  sic_row_t                 rows [8];

  always #25 clk = ~clk;

  sic_csr_top dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .priv_mode(priv_mode), .status_sie(status_sie),
    .supervisor_trap_return(trap_ret), .sup_external_pending(ext_p),
    .sup_timer_pending(tmr_p), .sup_software_set(sw_set), .real_time(rtime),
    .cnt_rd_valid(cnt_rd_valid), .cnt_rd_idx(cnt_rd_idx), .mach_cnt_enable(mach_en),
    .irq_req(irq_req), .irq_cause(irq_cause), .cnt_illegal(cnt_illegal),
    .cnt_grant(cnt_grant));

  sic_env_model env_u (.clk(clk), .rstn(rstn), .ext_cmd(ext_cmd), .tmr_cmd(tmr_cmd),
    .ipi_cmd(ipi_cmd), .sup_external_pending(ext_p), .sup_timer_pending(tmr_p),
    .sup_software_set(sw_set), .real_time(rtime));

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
    cmp(e, g);
  endtask

  task automatic chk_irq(input logic r, input logic [4:0] c);
    cmp({26'h0, r, c}, {26'h0, irq_req, irq_cause});
  endtask

  task automatic chk_cnt(input logic ill);
    cmp({30'h0, ill, ~ill}, {30'h0, cnt_illegal, cnt_grant});
  endtask

  // Bounded so a stuck slave cannot hang one transfer
  task automatic wait_rdy;
    int w;
    w = 0;
    do
    begin
      @(posedge clk);
      w++;
    end
    while (hreadyout !== 1'b1 && w < 20);
    if (w >= 20) n_fail++;
  endtask

  task automatic bus_go(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= SIC_HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    bus_go(a, 1'b1, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus_go(a, 1'b0, 32'h0);
    chk_reg(e, hrdata);
    // Response must always be OKAY
    cmp(32'h0, {31'h0, hresp});
  endtask

  function automatic logic [31:0] spread(input logic [2:0] b);
    return {22'h0, b[2], 3'h0, b[1], 3'h0, b[0], 1'h0};
  endfunction

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end

  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  // Row fields: priv, sie, enables {ext,tmr,sw}, sources, cause, counter enables
  initial
  begin
    rows = '{'{SIC_PRIV_S, 1'h1, 3'h7, 3'h7, 5'h09, 32'h0, 32'hFFFFFFFF, 5'h00, 1'h0},
             '{SIC_PRIV_S, 1'h1, 3'h7, 3'h3, 5'h01, 32'h0, 32'h0, 5'h01, 1'h0},
             '{SIC_PRIV_U, 1'h0, 3'h7, 3'h2, 5'h05, 32'h1, 32'h1, 5'h00, 1'h0},
             '{SIC_PRIV_U, 1'h0, 3'h2, 3'h6, 5'h05, 32'h2, 32'h0, 5'h01, 1'h1},
             '{SIC_PRIV_S, 1'h0, 3'h7, 3'h4, 5'h00, 32'h0, 32'hFFFFFFFF, 5'h02, 1'h0},
             '{SIC_PRIV_M, 1'h1, 3'h7, 3'h4, 5'h00, 32'h0, 32'h0, 5'h02, 1'h0},
             '{SIC_PRIV_U, 1'h1, 3'h4, 3'h0, 5'h00, 32'h4, 32'hFFFFFFFF, 5'h03, 1'h1},
             '{SIC_PRIV_U, 1'h0, 3'h7, 3'h5, 5'h09, 32'h80000000, 32'hFFFFFFFF, 5'h1F, 1'h0}};
    offs = '{SIC_OFF_PEND_LO, SIC_OFF_EN_LO, SIC_OFF_EN_HI, SIC_OFF_CNTEN,
             SIC_OFF_SCR_LO, SIC_OFF_SCR_HI, SIC_OFF_TCMP_LO, SIC_OFF_TCMP_HI};
    rexp = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
    begin
      priv_mode  <= rows[i].priv;
      status_sie <= rows[i].sie;
      mach_en    <= rows[i].mach;
      ext_cmd    <= rows[i].src[2];
      tmr_cmd    <= rows[i].src[1];
      bus_wr(SIC_OFF_EN_LO, spread(rows[i].en));
      bus_wr(SIC_OFF_PEND_LO, spread({2'h0, rows[i].src[0]}));
      bus_wr(SIC_OFF_CNTEN, rows[i].cnten);
      repeat (3) @(posedge clk);
      #1 chk_irq(rows[i].cause != 5'h00, rows[i].cause);
      @(posedge clk);
      cnt_rd_valid <= 1'b1;
      cnt_rd_idx   <= rows[i].idx;
      @(posedge clk);
      cnt_rd_valid <= 1'b0;
      #1 chk_cnt(rows[i].ill);
      @(posedge clk);
    end
    // Probe which sources exist
    ext_cmd <= 1'b0;
    bus_wr(SIC_OFF_EN_LO, 32'hFFFFFFFF);
    rd_chk(SIC_OFF_EN_LO, 32'h00000222);
    bus_wr(SIC_OFF_EN_HI, 32'hFFFFFFFF);
    rd_chk(SIC_OFF_EN_HI, 32'h0);
    bus_wr(SIC_OFF_PEND_LO, 32'hFFFFFFFF);
    rd_chk(SIC_OFF_PEND_LO, 32'h2);
    ext_cmd <= 1'b1;
    bus_wr(SIC_OFF_PEND_LO, 32'h0);
    rd_chk(SIC_OFF_PEND_LO, 32'h200);
    ext_cmd <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(SIC_OFF_PEND_LO, 32'h0);
    ipi_cmd <= 1'b1;
    @(posedge clk);
    ipi_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(SIC_OFF_PEND_LO, 32'h2);
    bus_wr(SIC_OFF_PEND_LO, 32'h0);
    bus_wr(SIC_OFF_TCMP_HI, 32'h0);
    bus_wr(SIC_OFF_TCMP_LO, 32'h0);
    repeat (3) @(posedge clk);
    rd_chk(SIC_OFF_PEND_LO, 32'h20);
    bus_wr(SIC_OFF_TCMP_LO, 32'hFFFFFFFF);
    bus_wr(SIC_OFF_TCMP_HI, 32'hFFFFFFFF);
    repeat (3) @(posedge clk);
    rd_chk(SIC_OFF_PEND_LO, 32'h0);
    bus_wr(SIC_OFF_SCR_LO, 32'hA5A50F0F);
    bus_wr(SIC_OFF_SCR_HI, 32'h12345678);
    rd_chk(SIC_OFF_SCR_LO, 32'hA5A50F0F);
    rd_chk(SIC_OFF_SCR_HI, 32'h12345678);
    bus_wr(8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'h0);
    // Return into S with global enable off, then on
    priv_mode  <= SIC_PRIV_U;
    status_sie <= 1'b0;
    bus_wr(SIC_OFF_EN_LO, 32'h2);
    bus_wr(SIC_OFF_PEND_LO, 32'h2);
    @(posedge clk);
    #1 chk_irq(1'b1, 5'h01);
    @(posedge clk);
    trap_ret  <= 1'b1;
    priv_mode <= SIC_PRIV_S;
    @(posedge clk);
    trap_ret <= 1'b0;
    @(posedge clk);
    #1 chk_irq(1'b0, 5'h00);
    @(posedge clk);
    status_sie <= 1'b1;
    rd_chk(SIC_OFF_STATUS, 32'h3D);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk_irq(1'b0, 5'h00);
    @(posedge clk);
    foreach (offs[i])
      rd_chk(offs[i], rexp[i]);
    tally_and_finish();
  end
endmodule
`default_nettype wire
